/* File: verilog/mesc_params.svh */
`ifndef MESC_PARAMS_SVH
`define MESC_PARAMS_SVH

// Register byte offsets: counters
`define MESC_OFS_ECOL 8'h00
`define MESC_OFS_TRANSMIT_UNDERRUN_FIELD 8'h04
`define MESC_OFS_CSE  8'h08
`define MESC_OFS_RRE  8'h0c
`define MESC_OFS_ROV  8'h10
`define MESC_OFS_RSE  8'h14
`define MESC_OFS_ELE  8'h18
`define MESC_OFS_RJA  8'h1c
`define MESC_OFS_USF  8'h20
`define MESC_OFS_STE  8'h24
`define MESC_OFS_RLE  8'h28
// Register byte offsets: control and interrupt
`define MESC_OFS_CFG  8'h2c
`define MESC_OFS_STS  8'h30
`define MESC_OFS_IEN  8'h34
`define MESC_OFS_ICLR 8'h38

// Configuration field positions
`define MESC_CFG_FDX_BIT    0
`define MESC_CFG_BIG_BIT    8
`define MESC_CFG_LENCHK_BIT 16

// Reset values
`define MESC_CNT_RST 16'h0000
`define MESC_CFG_RST 32'h0000_0000
`define MESC_IEN_RST 11'h000

// Frame length limits in bytes
`define MESC_LEN_MIN     16'd64
`define MESC_LEN_MAX     16'd1518
`define MESC_LEN_MAX_BIG 16'd1536
`define MESC_TYPE_MIN    16'h0600

// Collision check window after transmit end
`define MESC_SQE_BITS     96
`define MESC_BITS_PER_NIB 4

`endif

/* File: verilog/mesc_pkg.sv */
package mesc_pkg;
    typedef logic [31:0] mesc_word_t;
    typedef logic [7:0]  mesc_addr_t;
    typedef logic [15:0] mesc_len_t;
    typedef enum logic [0:0] {
        MESC_SQE_IDLE = 1'b0,
        MESC_SQE_WAIT = 1'b1
    } mesc_sqe_state_t;
endpackage

/* File: verilog/mesc_stat_counters.sv */
// Summary of operation
// - 8-bit counter of frames dropped after sixteen transmit collisions.
// - 8-bit counter of frames not sent because transmit DMA ran dry.
// - An underrun frame bumps only the underrun counter, nothing else.
// - 8-bit carrier error counter: no carrier, or carrier lost, clean frame.
// - Carrier errors are counted in half duplex only.
// - A carrier error affects no counter but its own.
// - 16-bit counter of matched frames dropped for lack of receive buffer.
// - 8-bit counter of matched frames lost to receive DMA overrun.
// - 8-bit counter of frames that saw receive error during reception.
// - Symbol error frames of legal size also count as FCS/alignment, or jabber if long.
// - 8-bit counter of overlong frames without CRC, alignment or symbol error.
// - 8-bit counter of overlong frames with CRC, alignment or symbol error.
// - 8-bit counter of short frames without CRC, alignment or symbol error.
// - Half duplex: count frames with no collision within 96 bit times.
// - If enabled, count frames shorter than their length field says.
// - Type values from 0x0600 and overlong frames are never mismatches.
`include "mesc_params.svh"

module mesc_stat_counters (
    // Clock and reset
    input  wire logic              clk_in,
    input  wire logic              nrst_in,
    // Register port
    input  wire mesc_pkg::mesc_addr_t addr_in,
    input  wire mesc_pkg::mesc_word_t wr_data_in,
    input  wire logic              wr_en_in,
    input  wire logic              rd_en_in,
    output mesc_pkg::mesc_word_t   rd_data_out,
    // Transmit frame status
    input  wire logic              tx_done_in,
    input  wire logic              tx_underrun_in,
    input  wire logic              tx_excess_col_in,
    input  wire logic              tx_collision_in,
    input  wire logic              tx_crs_seen_in,
    input  wire logic              tx_crs_lost_in,
    // Media interface lines
    input  wire logic              mii_tx_en_in,
    input  wire logic              mii_col_in,
    input  wire logic              mii_nibble_tick_in,
    input  wire logic              mii_rx_dv_in,
    input  wire logic              mii_rx_er_in,
    // Receive frame status
    input  wire logic              rx_done_in,
    input  wire mesc_pkg::mesc_len_t rx_frame_len_in,
    input  wire mesc_pkg::mesc_len_t rx_data_len_in,
    input  wire mesc_pkg::mesc_len_t rx_len_type_in,
    input  wire logic              rx_crc_err_in,
    input  wire logic              rx_align_err_in,
    input  wire logic              rx_addr_match_in,
    input  wire logic              rx_no_buffer_in,
    input  wire logic              rx_overrun_in,
    // Events to the FCS and alignment counters, and interrupt
    output logic                   fcs_err_event_out,
    output logic                   align_err_event_out,
    output logic                   irq_out
);
    import mesc_pkg::*;

    // Register map, one 32-bit word per register:
    //   0x00 excessive collisions, 8 bits
    //   0x04 transmit underruns, 8 bits
    //   0x08 carrier sense errors, 8 bits
    //   0x0c receive resource errors, 16 bits
    //   0x10 receive overruns, 8 bits
    //   0x14 receive symbol errors, 8 bits
    //   0x18 excessive length frames, 8 bits
    //   0x1c receive jabbers, 8 bits
    //   0x20 undersize frames, 8 bits
    //   0x24 collision check failures, 8 bits
    //   0x28 length field mismatches, 8 bits
    //   0x2c configuration, all bits kept
    //   0x30 interrupt status, read only
    //   0x34 interrupt enable
    //   0x38 interrupt clear, write only, reads 0
    // Configuration bits:
    //   bit 0 full duplex, stops carrier and collision checks
    //   bit 8 long frames allowed up to 1536 bytes
    //   bit 16 length field check on
    // Status and enable bit i belong to the counter at 4*i
    // Register port notes:
    //   Accesses with address bits 1:0 set are ignored
    //   Unmapped reads return zero
    //   Read data stand one cycle, zero otherwise
    //   Writes land at the strobe edge
    //   A write beats an increment in the same cycle
    //   An increment beats a clear in the same cycle
    //   Counters wrap at their own width
    // Transmit side notes:
    //   tx_done_in qualifies all transmit status bits
    //   An underrun frame touches only its own counter
    //   Carrier checks need half duplex and no collision
    // Receive side notes:
    //   rx_done_in qualifies all receive status bits
    //   Symbol errors are gathered between frame ends
    //   A symbol error in the end cycle still counts
    //   Only the long limit follows configuration bit 8; the short limit stays 64
    //   Symbol error frames of legal size raise an event
    //   The event picks checksum or alignment by the align flag
    //   Events leave for counters outside this block
    // Collision check notes:
    //   The window opens on the falling edge of transmit enable
    //   It lasts 24 nibble ticks, 96 bit times
    //   Collision, new transmit or full duplex closes it
    //   The nibble tick must be slower than the clock
    //   The counter steps one cycle after the window ends
    // Hazards:
    //   Counter index comes from address bits 7:2
    //   Offsets past the counters skip the counter array
    //   Status read pads the 11 flags with zeros
    //   The interrupt changes in the same cycle as status and enable
    // Reset notes:
    //   All counters, flags and configuration clear
    //   Configuration clears to half duplex, short limits
    //   Interrupt enables clear, so the interrupt stays low
    //   Read data and event outputs clear
    //   The collision window closes
    //   Transmit enable history clears to idle low
    // Limitations:
    //   No counter saturates; software must poll in time
    //   Frame lengths above 65535 bytes cannot be shown
    //   Only one transmit and one receive result per cycle
    //   Both strobes at once are not supported
    //   Inputs are taken as synchronous to clk_in
    //   The length check trusts the measured data length input
    //   Status flags clear only through the clear register
    //   Writes to status are ignored
    //   Counters reset to zero

    localparam int NUM_CNT = 11;
    localparam int SQE_NIBS = `MESC_SQE_BITS / `MESC_BITS_PER_NIB;
    localparam logic [4:0] SQE_LAST = 5'(SQE_NIBS - 1);

    // Counter index from its register offset
    function automatic int cidx(input logic [7:0] ofs);
        cidx = int'(ofs[7:2]);
    endfunction

    // Significant bits of each counter
    function automatic logic [15:0] cmask(input int i);
        cmask = (i == cidx(`MESC_OFS_RRE)) ? 16'hffff : 16'h00ff;
    endfunction

    // Register state
    logic [15:0]         cnt_q [NUM_CNT];
    logic [15:0]         cnt_d [NUM_CNT];
    mesc_word_t          cfg_q, cfg_d;
    logic [NUM_CNT-1:0]  sts_q, sts_d;
    logic [NUM_CNT-1:0]  ien_q, ien_d;
    logic [NUM_CNT-1:0]  inc;
    logic                irq_q, irq_d;
    logic                fcs_q, fcs_d;
    logic                aln_q, aln_d;
    mesc_word_t          rd_q, rd_d;
    // Receive error tracking
    logic                sym_q, sym_d;
    // Collision check after transmit end
    mesc_sqe_state_t     sqe_st_q, sqe_st_d;
    logic [4:0]          sqe_cnt_q, sqe_cnt_d;
    logic                txen_q, txen_d;
    logic                sqe_fire_q, sqe_fire_d;

    logic                half_dpx;
    logic                wr_ok;
    logic                frame_sym;
    logic [15:0]         len_max;
    logic                rx_long;
    logic                rx_short;
    logic                rx_bad;

    assign half_dpx  = ~cfg_q[`MESC_CFG_FDX_BIT];
    assign wr_ok     = wr_en_in && (addr_in[1:0] == 2'b00);
    assign frame_sym = sym_q | (mii_rx_dv_in & mii_rx_er_in);
    assign len_max   = cfg_q[`MESC_CFG_BIG_BIT] ? `MESC_LEN_MAX_BIG : `MESC_LEN_MAX;
    assign rx_long   = rx_frame_len_in > len_max;
    assign rx_short  = rx_frame_len_in < `MESC_LEN_MIN;
    assign rx_bad    = rx_crc_err_in | rx_align_err_in | frame_sym;

    // Receive error seen while data valid, held until frame end
    always_comb begin
        sym_d = sym_q;
        if (rx_done_in) begin
            sym_d = 1'b0;
        end else if (mii_rx_dv_in && mii_rx_er_in) begin
            sym_d = 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sym_q <= 1'b0;
        end else begin
            sym_q <= sym_d;
        end
    end

    // Collision check window opened by the falling edge of transmit enable
    always_comb begin
        sqe_st_d   = sqe_st_q;
        sqe_cnt_d  = sqe_cnt_q;
        sqe_fire_d = 1'b0;
        txen_d     = mii_tx_en_in;
        case (sqe_st_q)
            MESC_SQE_IDLE: begin
                if (txen_q && !mii_tx_en_in && half_dpx) begin
                    sqe_st_d  = MESC_SQE_WAIT;
                    sqe_cnt_d = 5'h00;
                end
            end
            MESC_SQE_WAIT: begin
                if (mii_col_in || mii_tx_en_in || !half_dpx) begin
                    sqe_st_d = MESC_SQE_IDLE;
                end else if (mii_nibble_tick_in) begin
                    sqe_cnt_d = sqe_cnt_q + 5'h01;
                    if (sqe_cnt_q == SQE_LAST) begin
                        sqe_st_d   = MESC_SQE_IDLE;
                        sqe_fire_d = 1'b1;
                    end
                end
            end
            default: begin
                sqe_st_d = MESC_SQE_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sqe_st_q   <= MESC_SQE_IDLE;
            sqe_cnt_q  <= 5'h00;
            sqe_fire_q <= 1'b0;
            txen_q     <= 1'b0;
        end else begin
            sqe_st_q   <= sqe_st_d;
            sqe_cnt_q  <= sqe_cnt_d;
            sqe_fire_q <= sqe_fire_d;
            txen_q     <= txen_d;
        end
    end

    // Frame events to counter increments
    always_comb begin
        inc   = '0;
        fcs_d = 1'b0;
        aln_d = 1'b0;
        if (tx_done_in) begin
            if (tx_underrun_in) begin
                inc[cidx(`MESC_OFS_TRANSMIT_UNDERRUN_FIELD)] = 1'b1;
            end else begin
                inc[cidx(`MESC_OFS_ECOL)] = tx_excess_col_in;
                // Carrier error only adds to its own counter
                inc[cidx(`MESC_OFS_CSE)] = half_dpx && !tx_collision_in &&
                    (!tx_crs_seen_in || tx_crs_lost_in);
            end
        end
        if (rx_done_in) begin
            inc[cidx(`MESC_OFS_RRE)] = rx_addr_match_in & rx_no_buffer_in;
            inc[cidx(`MESC_OFS_ROV)] = rx_addr_match_in & rx_overrun_in;
            inc[cidx(`MESC_OFS_RSE)] = frame_sym;
            inc[cidx(`MESC_OFS_ELE)] = rx_long & ~rx_bad;
            inc[cidx(`MESC_OFS_RJA)] = rx_long & rx_bad;
            inc[cidx(`MESC_OFS_USF)] = rx_short & ~rx_bad;
            inc[cidx(`MESC_OFS_RLE)] = cfg_q[`MESC_CFG_LENCHK_BIT] &&
                (rx_len_type_in < `MESC_TYPE_MIN) && !rx_long &&
                (rx_data_len_in < rx_len_type_in);
            if (frame_sym && !rx_short && !rx_long) begin
                fcs_d = ~rx_align_err_in;
                aln_d = rx_align_err_in;
            end
        end
        inc[cidx(`MESC_OFS_STE)] = sqe_fire_q;
    end

    // Counters, configuration, interrupt status and enable
    always_comb begin
        for (int i = 0; i < NUM_CNT; i++) begin
            if (wr_ok && (int'(addr_in[7:2]) == i)) begin
                cnt_d[i] = wr_data_in[15:0] & cmask(i);
            end else if (inc[i]) begin
                cnt_d[i] = (cnt_q[i] + 16'h0001) & cmask(i);
            end else begin
                cnt_d[i] = cnt_q[i];
            end
        end
        cfg_d = cfg_q;
        ien_d = ien_q;
        sts_d = sts_q;
        if (wr_ok && addr_in == `MESC_OFS_CFG) begin
            cfg_d = wr_data_in;
        end
        if (wr_ok && addr_in == `MESC_OFS_IEN) begin
            ien_d = wr_data_in[NUM_CNT-1:0];
        end
        if (wr_ok && addr_in == `MESC_OFS_ICLR) begin
            sts_d = sts_q & ~wr_data_in[NUM_CNT-1:0];
        end
        sts_d = sts_d | inc; // Set wins over clear
        irq_d = |(sts_d & ien_d);
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            for (int i = 0; i < NUM_CNT; i++) begin
                cnt_q[i] <= `MESC_CNT_RST;
            end
            cfg_q <= `MESC_CFG_RST;
            ien_q <= `MESC_IEN_RST;
            sts_q <= '0;
            irq_q <= 1'b0;
            fcs_q <= 1'b0;
            aln_q <= 1'b0;
        end else begin
            for (int i = 0; i < NUM_CNT; i++) begin
                cnt_q[i] <= cnt_d[i];
            end
            cfg_q <= cfg_d;
            ien_q <= ien_d;
            sts_q <= sts_d;
            irq_q <= irq_d;
            fcs_q <= fcs_d;
            aln_q <= aln_d;
        end
    end

    // Read data, valid only in the cycle after the read strobe
    always_comb begin
        rd_d = '0;
        if (rd_en_in && addr_in[1:0] == 2'b00) begin
            if (int'(addr_in[7:2]) < NUM_CNT) begin
                rd_d = {16'h0000, cnt_q[addr_in[5:2]]};
            end else if (addr_in == `MESC_OFS_CFG) begin
                rd_d = cfg_q;
            end else if (addr_in == `MESC_OFS_STS) begin
                rd_d = {21'h000000, sts_q};
            end else if (addr_in == `MESC_OFS_IEN) begin
                rd_d = {21'h000000, ien_q};
            end
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rd_q <= '0;
        end else begin
            rd_q <= rd_d;
        end
    end

    assign rd_data_out         = rd_q;
    assign irq_out             = irq_q;
    assign fcs_err_event_out   = fcs_q;
    assign align_err_event_out = aln_q;

endmodule

/* File: testbench/mesc_checker.sv */
module mesc_checker (
    // Clock, reset and register port
    input wire logic                 clk_in,
    input wire logic                 nrst_in,
    input wire mesc_pkg::mesc_addr_t addr_in,
    input wire mesc_pkg::mesc_word_t wr_data_in,
    input wire logic                 wr_en_in,
    input wire logic                 rd_en_in,
    input wire mesc_pkg::mesc_word_t rd_data_out,
    // Receive status and events
    input wire logic                 rx_done_in,
    input wire mesc_pkg::mesc_len_t  rx_frame_len_in,
    input wire logic                 rx_align_err_in,
    input wire logic                 fcs_err_event_out,
    input wire logic                 align_err_event_out,
    input wire logic                 irq_out
);
    timeunit 1ns;
    timeprecision 1ns;
    import mesc_pkg::*;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!nrst_in);
    // Register port answers
    property p_rd_idle; !$past(rd_en_in) |-> rd_data_out == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
    property p_nomap; rd_en_in && addr_in >= 8'h38 |=> rd_data_out == 32'h0; endproperty
    a_nomap: assert property (p_nomap) else $error("unmapped read not zero");
    property p_up8;
        rd_en_in && addr_in <= 8'h28 && addr_in[1:0] == 2'b00 && addr_in != 8'h0c
        |=> rd_data_out[31:8] == 24'h0;
    endproperty
    a_up8: assert property (p_up8) else $error("upper bits of 8-bit counter set");
    property p_up16; rd_en_in && addr_in == 8'h0c |=> rd_data_out[31:16] == 16'h0; endproperty
    a_up16: assert property (p_up16) else $error("upper bits of 16-bit counter set");
    // Receive event pulses
    property p_fcs;
        fcs_err_event_out |-> $past(rx_done_in && !rx_align_err_in
            && rx_frame_len_in >= 16'd64 && rx_frame_len_in <= 16'd1536);
    endproperty
    a_fcs: assert property (p_fcs) else $error("fcs event without cause");
    property p_aln;
        align_err_event_out |-> $past(rx_done_in && rx_align_err_in
            && rx_frame_len_in >= 16'd64 && rx_frame_len_in <= 16'd1536);
    endproperty
    a_aln: assert property (p_aln) else $error("align event without cause");
    property p_long;
        rx_done_in && rx_frame_len_in > 16'd1536 |=> !fcs_err_event_out && !align_err_event_out;
    endproperty
    a_long: assert property (p_long) else $error("long frame gave event");
    property p_one; !(fcs_err_event_out && align_err_event_out); endproperty
    a_one: assert property (p_one) else $error("both events at once");
    // Interrupt follows the enable register
    property p_irq; wr_en_in && addr_in == 8'h34 && wr_data_in == 32'h0 |-> ##2 !irq_out; endproperty
    a_irq: assert property (p_irq) else $error("irq high with no enable");
endmodule

bind mesc_stat_counters mesc_checker u_chk (.clk_in(clk_in), .nrst_in(nrst_in),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
    .rd_data_out(rd_data_out), .rx_done_in(rx_done_in), .rx_frame_len_in(rx_frame_len_in),
    .rx_align_err_in(rx_align_err_in), .fcs_err_event_out(fcs_err_event_out),
    .align_err_event_out(align_err_event_out), .irq_out(irq_out));

/* File: testbench/mesc_phy_model.sv */
module mesc_phy_model (
    // Clock and bench controls
    input  wire logic clk_in,
    input  wire logic tx_en_in,
    input  wire logic sqe_on_in,
    input  wire logic rx_go_in,
    input  wire logic rx_bad_in,
    // Media lines toward the counters
    output logic      col_out,
    output logic      tick_out,
    output logic      rx_dv_out,
    output logic      rx_er_out
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] rcnt_q = 3'h0;
    logic [6:0] gap_q  = 7'h7f;
    logic       tog_q  = 1'b0;
    logic       txen_q = 1'b0;
    // Nibble tick at half clock rate, frame length and post-transmit gap
    always_ff @(posedge clk_in) begin
        tog_q  <= ~tog_q;
        txen_q <= tx_en_in;
        rcnt_q <= rx_go_in ? 3'h4 : (rcnt_q != 3'h0 ? rcnt_q - 3'h1 : 3'h0);
        gap_q  <= (txen_q && !tx_en_in) ? 7'h0 : (gap_q != 7'h7f ? gap_q + 7'h1 : gap_q);
    end
    // Heartbeat collision early in the gap; receive error noise outside frames
    assign tick_out  = tog_q;
    assign col_out   = sqe_on_in && gap_q >= 7'h4 && gap_q < 7'h8;
    assign rx_dv_out = rcnt_q != 3'h0;
    assign rx_er_out = rx_dv_out ? (rx_bad_in && rcnt_q == 3'h2) : tog_q;
endmodule

/* File: testbench/mesc_stat_counters_tb_top.sv */
module mesc_stat_counters_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import mesc_pkg::*;
    logic       clk_in = 1'b0, nrst_in = 1'b0, wr_en_in = 1'b0, rd_en_in = 1'b0;
    mesc_addr_t addr_in = 8'h0;
    mesc_word_t wr_data_in = 32'h0, rd_data_out;
    logic [4:0] txf = 5'h0, rxf = 5'h0; // underrun excess col seen lost; crc align match nobuf ovr
    logic       tx_done = 1'b0, tx_en = 1'b0, sqe_on = 1'b0, rx_go = 1'b0, rx_bad = 1'b0;
    logic       rx_done = 1'b0, col, tick, dv, er, fcs_ev, align_ev, irq_out;
    mesc_len_t  rx_len = 16'h0, rx_dlen = 16'h0, rx_lt = 16'h0;
    logic [1:0] ev_q;
    int         bad_count = 0, n_compared = 0;
    mesc_stat_counters u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
        .wr_data_in(wr_data_in), .wr_en_in(wr_en_in), .rd_en_in(rd_en_in),
        .rd_data_out(rd_data_out), .tx_done_in(tx_done), .tx_underrun_in(txf[4]),
        .tx_excess_col_in(txf[3]), .tx_collision_in(txf[2]), .tx_crs_seen_in(txf[1]),
        .tx_crs_lost_in(txf[0]), .mii_tx_en_in(tx_en), .mii_col_in(col),
        .mii_nibble_tick_in(tick), .mii_rx_dv_in(dv), .mii_rx_er_in(er), .rx_done_in(rx_done),
        .rx_frame_len_in(rx_len), .rx_data_len_in(rx_dlen), .rx_len_type_in(rx_lt),
        .rx_crc_err_in(rxf[4]), .rx_align_err_in(rxf[3]), .rx_addr_match_in(rxf[2]),
        .rx_no_buffer_in(rxf[1]), .rx_overrun_in(rxf[0]), .fcs_err_event_out(fcs_ev),
        .align_err_event_out(align_ev), .irq_out(irq_out));
    mesc_phy_model u_phy (.clk_in(clk_in), .tx_en_in(tx_en), .sqe_on_in(sqe_on),
        .rx_go_in(rx_go), .rx_bad_in(rx_bad), .col_out(col), .tick_out(tick),
        .rx_dv_out(dv), .rx_er_out(er));
    // Clock at 50 ns period
    initial forever #25 clk_in = ~clk_in;
    // Shared compare, bus cycles and frame drivers
    task automatic chk(input string n, input mesc_word_t e, input mesc_word_t s);
        n_compared++;
        if (s !== e) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask
    task automatic wr(input mesc_addr_t a, input mesc_word_t d);
        @(posedge clk_in);
        {addr_in, wr_data_in, wr_en_in} <= {a, d, 1'b1};
        @(posedge clk_in);
        wr_en_in <= 1'b0;
    endtask
    task automatic rd(input mesc_addr_t a, input mesc_word_t e);
        @(posedge clk_in);
        {addr_in, rd_en_in} <= {a, 1'b1};
        @(posedge clk_in);
        rd_en_in <= 1'b0;
        #1 chk($sformatf("reg_%h", a), e, rd_data_out);
    endtask
    task automatic tx(input logic [4:0] f);
        @(posedge clk_in);
        {txf, tx_done} <= {f, 1'b1};
        @(posedge clk_in);
        tx_done <= 1'b0;
    endtask
    task automatic rx(input mesc_len_t l, input mesc_len_t d, input mesc_len_t t,
                      input logic [4:0] f, input logic b);
        @(posedge clk_in);
        {rx_go, rx_bad} <= {1'b1, b};
        @(posedge clk_in);
        rx_go <= 1'b0;
        repeat (5) @(posedge clk_in);
        {rx_len, rx_dlen, rx_lt, rxf, rx_done} <= {l, d, t, f, 1'b1};
        @(posedge clk_in);
        rx_done <= 1'b0;
        #1 ev_q = {fcs_ev, align_ev};
    endtask
    task automatic sqe(input logic on, input int n);
        @(posedge clk_in);
        {sqe_on, tx_en} <= {on, 1'b1};
        @(posedge clk_in);
        tx_en <= 1'b0;
        repeat (n) @(posedge clk_in);
    endtask
    // Transmit outcomes
    task automatic t_tx;
        tx(5'b01100);
        tx(5'b10000);
        rd(8'h00, 32'h1);
        rd(8'h04, 32'h1);
        rd(8'h08, 32'h0);
        tx(5'b00000);
        tx(5'b00011);
        tx(5'b00100);
        rd(8'h08, 32'h2);
        rd(8'h00, 32'h1);
        wr(8'h2c, 32'h1);
        tx(5'b00000);
        rd(8'h08, 32'h2);
        $display("test tx done");
    endtask
    // Receive outcomes and length limits
    task automatic t_rx;
        wr(8'h2c, 32'h0);
        rx(16'd100, 16'd46, 16'd46, 5'b00110, 1'b0);
        rx(16'd100, 16'd46, 16'd46, 5'b00101, 1'b0);
        rx(16'd100, 16'd46, 16'd46, 5'b00100, 1'b1);
        chk("events", 32'h2, {30'h0, ev_q});
        rx(16'd100, 16'd46, 16'd46, 5'b01100, 1'b1);
        chk("events", 32'h1, {30'h0, ev_q});
        rx(16'd1600, 16'd46, 16'd46, 5'b00100, 1'b1);
        chk("events", 32'h0, {30'h0, ev_q});
        rx(16'd1519, 16'd46, 16'd46, 5'b00100, 1'b0);
        rx(16'd1600, 16'd46, 16'd46, 5'b10100, 1'b0);
        rx(16'd63, 16'd46, 16'd46, 5'b00100, 1'b0);
        rx(16'd64, 16'd46, 16'd46, 5'b00100, 1'b0);
        rx(16'd63, 16'd46, 16'd46, 5'b10100, 1'b0);
        wr(8'h2c, 32'h100);
        rx(16'd1536, 16'd46, 16'd46, 5'b00100, 1'b0);
        rx(16'd1537, 16'd46, 16'd46, 5'b00100, 1'b0);
        rd(8'h0c, 32'h1);
        rd(8'h10, 32'h1);
        rd(8'h14, 32'h3);
        rd(8'h18, 32'h2);
        rd(8'h1c, 32'h2);
        rd(8'h20, 32'h1);
        $display("test rx done");
    endtask
    // Length field check
    task automatic t_len;
        wr(8'h2c, 32'h1_0000);
        rx(16'd100, 16'd40, 16'd46, 5'b00100, 1'b0);
        rx(16'd100, 16'd40, 16'h05ff, 5'b00100, 1'b0);
        rx(16'd100, 16'd40, 16'h0600, 5'b00100, 1'b0);
        rx(16'd1600, 16'd40, 16'd46, 5'b10100, 1'b0);
        rx(16'd100, 16'd46, 16'd46, 5'b00100, 1'b0);
        wr(8'h2c, 32'h0);
        rx(16'd100, 16'd40, 16'd46, 5'b00100, 1'b0);
        rd(8'h28, 32'h2);
        $display("test len done");
    endtask
    // Collision heartbeat after transmit
    task automatic t_sqe;
        sqe(1'b0, 40);
        rd(8'h24, 32'h0);
        repeat (20) @(posedge clk_in);
        rd(8'h24, 32'h1);
        sqe(1'b1, 60);
        wr(8'h2c, 32'h1);
        sqe(1'b0, 60);
        rd(8'h24, 32'h1);
        wr(8'h2c, 32'h0);
        $display("test sqe done");
    endtask
    // Direct load, wrap and interrupt
    task automatic t_irq;
        rd(8'h3c, 32'h0);
        wr(8'h0c, 32'h1234_5678);
        rd(8'h0c, 32'h0000_5678);
        wr(8'h00, 32'h0000_01ff);
        rd(8'h00, 32'h0000_00ff);
        wr(8'h38, 32'h0000_07ff);
        tx(5'b01100);
        rd(8'h00, 32'h0);
        chk("irq_masked", 32'h0, {31'h0, irq_out});
        rd(8'h30, 32'h1);
        wr(8'h34, 32'h1);
        @(posedge clk_in);
        #1 chk("irq_on", 32'h1, {31'h0, irq_out});
        wr(8'h38, 32'h1);
        @(posedge clk_in);
        #1 chk("irq_clr", 32'h0, {31'h0, irq_out});
        rd(8'h38, 32'h0);
        wr(8'h34, 32'h0);
        $display("test irq done");
    endtask
    // Verdict
    task automatic results;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Watchdog well beyond the expected run
    initial begin
        #1000000;
        bad_count++;
        results();
    end
    // Main sequence
    initial begin
        repeat (2) @(posedge clk_in);
        nrst_in <= 1'b1;
        rd(8'h04, 32'h0);
        rd(8'h2c, 32'h0);
        t_tx();
        t_rx();
        t_len();
        t_sqe();
        t_irq();
        results();
    end
endmodule
